//--- asq_scan_sequencer.sv
// Behaviour
// - only channels with select bit set convert
// - each result lands in its channel's register
// - writing start bit one begins a scan if any channel is selected
// - single scan converts once, flags at end
// - continuous scan repeats, flags each full pass
// - interrupt needs enables and higher priority
// - completion flag cleared only by software
// - control bit 2 picks continuous or single
// - start bit reads one while scanning
// - start write while busy is ignored
// - writing start bit zero aborts scanning
// - timing field is low four bits
// - conversion time follows sixteen-entry table
// - sampling time follows sixteen-entry table
// - control, select, timing reset to zero
// - unimplemented bits read, reset as zero
// - only low byte of bus is used
`include "asq_map.svh"

module asq_scan_sequencer
  import asq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [10:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [15:0] sfr_wdata,
  output      logic [15:0] sfr_rdata,
  input  wire logic [7:0]  conv_data,
  input  wire logic        converter_irq_enable,
  input  wire logic        global_irq_enable,
  input  wire logic [3:0]  converter_priority,
  input  wire logic [3:0]  running_priority,
  input  wire logic [3:0]  pending_priority,
  output      logic        sample_en,
  output      logic        conv_active,
  output      logic [2:0]  conv_channel,
  output      logic        adc_irq_req
);

  asq_regs_t  st_ff;
  asq_regs_t  nxt_st;
  logic       wr_ctl;
  logic       wr_sel;
  logic       wr_cfg;
  logic [7:0] wbyte;
  logic [3:0] first_sel;
  logic [3:0] next_sel;
  logic [7:0] samp_clks;
  logic [7:0] conv_clks;
  logic       last_chan;

  // search upward for a selected channel; bit 3 says one was found
  function automatic logic [3:0] asq_find(input logic [7:0] mask,
                                          input logic [2:0] from,
                                          input logic       incl);
    logic [3:0] hit;
    hit = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (mask[i] && ((i > int'(from)) || incl)) begin
        hit = {1'b1, 3'(i)};
      end
    end
    return hit;
  endfunction : asq_find

  // bus decode; only the low byte of a wide write is used
  assign wbyte  = sfr_wdata[7:0];
  assign wr_ctl = sfr_wr && (sfr_addr == `ASQ_CTL_ADDR);
  assign wr_sel = sfr_wr && (sfr_addr == `ASQ_SEL_ADDR);
  assign wr_cfg = sfr_wr && (sfr_addr == `ASQ_CFG_ADDR);

  // timing lookups indexed by the stored timing field
  localparam logic [127:0] CONV_TAB = `ASQ_CONV_TABLE;
  localparam logic [127:0] SAMP_TAB = `ASQ_SAMP_TABLE;
  assign conv_clks = CONV_TAB[{st_ff.tcfg, 3'b000} +: 8];
  assign samp_clks = SAMP_TAB[{st_ff.tcfg, 3'b000} +: 8];

  // channel search uses the live mask so edits take effect next channel
  assign first_sel = asq_find(st_ff.chsel, 3'h0, 1'b1);
  assign next_sel  = asq_find(st_ff.chsel, st_ff.chan, 1'b0);
  assign last_chan = !next_sel[3];

  // next-state logic for registers, sequencer and interrupt request
  always_comb begin
    nxt_st = st_ff;
    // request needs both enables and priority above running and pending
    nxt_st.irq = st_ff.flag && converter_irq_enable && global_irq_enable
                 && (converter_priority > running_priority)
                 && (converter_priority > pending_priority);
    // register reads answer one cycle later; unused bits read zero
    if (sfr_rd) begin
      nxt_st.rdata = 8'h00;
      if (sfr_addr == `ASQ_CTL_ADDR) begin
        nxt_st.rdata[`ASQ_CTL_MODE_BIT]  = st_ff.mode;
        nxt_st.rdata[`ASQ_CTL_START_BIT] = st_ff.start;
        nxt_st.rdata[`ASQ_CTL_FLAG_BIT]  = st_ff.flag;
      end else if (sfr_addr == `ASQ_SEL_ADDR) begin
        nxt_st.rdata = st_ff.chsel;
      end else if (sfr_addr == `ASQ_CFG_ADDR) begin
        nxt_st.rdata = {4'h0, st_ff.tcfg};
      end else if (sfr_addr[10:3] == `ASQ_RES_BASE_HI) begin
        nxt_st.rdata = st_ff.res[sfr_addr[2:0]];
      end
    end
    // plain register writes; reserved bits are simply not stored
    if (wr_sel) begin
      nxt_st.chsel = wbyte;
    end
    if (wr_cfg) begin
      nxt_st.tcfg = wbyte[3:0];
    end
    if (wr_ctl) begin
      nxt_st.mode = wbyte[`ASQ_CTL_MODE_BIT];
      nxt_st.flag = wbyte[`ASQ_CTL_FLAG_BIT];
    end
    // scan sequencer
    unique case (st_ff.fsm)
      ASQ_IDLE: begin
        // starts are decoded only here, so a busy start is ignored
        // an empty mask leaves nothing to convert, so no start
        if (wr_ctl && wbyte[`ASQ_CTL_START_BIT] && first_sel[3]) begin
          nxt_st.start = 1'b1;
          nxt_st.chan  = first_sel[2:0];
          nxt_st.cnt   = samp_clks - 8'h01;
          nxt_st.samp  = 1'b1;
          nxt_st.fsm   = ASQ_SAMPLE;
        end
      end
      ASQ_SAMPLE: begin
        if (st_ff.cnt == 8'h00) begin
          // conversion time includes the sampling window
          nxt_st.cnt  = conv_clks - samp_clks - 8'h01;
          nxt_st.samp = 1'b0;
          nxt_st.conv = 1'b1;
          nxt_st.fsm  = ASQ_CONVERT;
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
      ASQ_CONVERT: begin
        if (st_ff.cnt == 8'h00) begin
          // capture in the last convert cycle, once the core has settled
          nxt_st.res[st_ff.chan] = conv_data;
          nxt_st.conv = 1'b0;
          if (!last_chan) begin
            nxt_st.chan = next_sel[2:0];
            nxt_st.cnt  = samp_clks - 8'h01;
            nxt_st.samp = 1'b1;
            nxt_st.fsm  = ASQ_SAMPLE;
          end else begin
            // hardware set outranks a software clear in the same cycle
            nxt_st.flag = 1'b1;
            if (st_ff.mode && first_sel[3]) begin
              nxt_st.chan = first_sel[2:0];
              nxt_st.cnt  = samp_clks - 8'h01;
              nxt_st.samp = 1'b1;
              nxt_st.fsm  = ASQ_SAMPLE;
            end else begin
              nxt_st.start = 1'b0;
              nxt_st.fsm   = ASQ_IDLE;
            end
          end
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
    endcase
    // a start write while busy is ignored; a zero write aborts
    if (wr_ctl && !wbyte[`ASQ_CTL_START_BIT] && st_ff.start) begin
      nxt_st.start = 1'b0;
      nxt_st.samp  = 1'b0;
      nxt_st.conv  = 1'b0;
      nxt_st.cnt   = 8'h00;
      nxt_st.fsm   = ASQ_IDLE;
    end
  end

  // state register; every stored field resets to zero except fsm, which resets to ASQ_IDLE
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.fsm   <= ASQ_IDLE;
      {st_ff.mode, st_ff.start, st_ff.flag} <= `ASQ_CTL_RESET;
      st_ff.chsel <= `ASQ_SEL_RESET;
      st_ff.tcfg  <= `ASQ_CFG_RESET;
      st_ff.chan  <= 3'h0;
      st_ff.cnt   <= 8'h00;
      st_ff.res   <= {8{`ASQ_RES_RESET}};
      st_ff.rdata <= 8'h00;
      st_ff.irq   <= 1'b0;
      st_ff.samp  <= 1'b0;
      st_ff.conv  <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops; upper read byte is a constant zero
  assign sfr_rdata    = {8'h00, st_ff.rdata};
  assign sample_en    = st_ff.samp;
  assign conv_active  = st_ff.conv;
  assign conv_channel = st_ff.chan;
  assign adc_irq_req  = st_ff.irq;

  // helper: cycles spent in the current sampling window
  logic [7:0] samp_run_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      samp_run_ff <= 8'h00;
    end else begin
      samp_run_ff <= st_ff.samp ? samp_run_ff + 8'h01 : 8'h00;
    end
  end

  // checks share the sequencer clock and are off while reset is low
  default clocking asq_cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_result_store: assert property (
    (st_ff.fsm == ASQ_CONVERT && st_ff.cnt == 8'h00 &&
     !(wr_ctl && !wbyte[`ASQ_CTL_START_BIT]))
    |=> st_ff.res[$past(st_ff.chan)] == $past(conv_data))
    else $error("result not stored in its channel register");

  a_start_begins: assert property (
    (st_ff.fsm == ASQ_IDLE && wr_ctl && wbyte[`ASQ_CTL_START_BIT] &&
     first_sel[3])
    |=> st_ff.start && sample_en && st_ff.chsel[conv_channel])
    else $error("scan did not begin on start write");

  a_single_end: assert property (
    (st_ff.fsm == ASQ_CONVERT && st_ff.cnt == 8'h00 && last_chan &&
     !st_ff.mode && !wr_ctl)
    |=> st_ff.flag && !st_ff.start && st_ff.fsm == ASQ_IDLE)
    else $error("single scan did not finish cleanly");

  a_cont_wrap: assert property (
    (st_ff.fsm == ASQ_CONVERT && st_ff.cnt == 8'h00 && last_chan &&
     st_ff.mode && first_sel[3] && !wr_ctl)
    |=> st_ff.flag && st_ff.start && sample_en)
    else $error("continuous scan did not wrap");

  a_irq_gate: assert property (
    adc_irq_req |-> $past(st_ff.flag) && $past(global_irq_enable) &&
    $past(converter_irq_enable) &&
    ($past(converter_priority) > $past(running_priority)) &&
    ($past(converter_priority) > $past(pending_priority)))
    else $error("interrupt requested without enables or priority");

  a_flag_sticky: assert property (
    (st_ff.flag && !wr_ctl) |=> st_ff.flag)
    else $error("completion flag cleared by hardware");

  a_busy_start: assert property (
    (sample_en || conv_active) |-> st_ff.start)
    else $error("start bit low while converting");

  a_restart_ign: assert property (
    (st_ff.fsm == ASQ_SAMPLE && st_ff.cnt != 8'h00 && wr_ctl &&
     wbyte[`ASQ_CTL_START_BIT])
    |=> sample_en && $stable(conv_channel) &&
        st_ff.cnt == $past(st_ff.cnt) - 8'h01)
    else $error("start write disturbed a running scan");

  a_abort_stop: assert property (
    (st_ff.start && wr_ctl && !wbyte[`ASQ_CTL_START_BIT])
    |=> !st_ff.start && !sample_en && !conv_active
        ##1 !sample_en && !conv_active)
    else $error("abort did not stop the scan");

  a_sample_len: assert property (
    $fell(sample_en) && $past(st_ff.start) && st_ff.start
    |-> $past(samp_run_ff) == $past(samp_clks) - 8'h01)
    else $error("sampling window length wrong");

  // further checks: stores, reads, the request gate and sequencer state and count loads
  a_select_only: assert property (
    $rose(sample_en) && !$past(wr_sel)
    |-> st_ff.chsel[conv_channel])
    else $error("unselected channel entered sampling");

  a_sel_store: assert property (
    wr_sel |=> st_ff.chsel == $past(wbyte))
    else $error("channel select write not stored");

  a_mode_store: assert property (
    wr_ctl |=> st_ff.mode == $past(wbyte[`ASQ_CTL_MODE_BIT]))
    else $error("scan mode write not stored");

  a_timing_low: assert property (
    wr_cfg |=> st_ff.tcfg == $past(wbyte[3:0]))
    else $error("timing field write not stored");

  a_unimpl_zero: assert property (
    (sfr_rd && sfr_addr == `ASQ_CTL_ADDR)
    |=> sfr_rdata[15:3] == 13'h0000)
    else $error("unused control bits read nonzero");

  a_idle_quiet: assert property (
    st_ff.fsm == ASQ_IDLE |-> !st_ff.start && !sample_en && !conv_active)
    else $error("idle sequencer shows activity");

  a_irq_clear: assert property (
    !st_ff.flag |=> !adc_irq_req)
    else $error("interrupt requested without completion flag");

  a_irq_rise: assert property (
    (st_ff.flag && converter_irq_enable && global_irq_enable &&
     (converter_priority > running_priority) &&
     (converter_priority > pending_priority))
    |=> adc_irq_req)
    else $error("interrupt not requested when allowed");

  a_start_empty: assert property (
    (st_ff.fsm == ASQ_IDLE && wr_ctl && !first_sel[3])
    |=> st_ff.fsm == ASQ_IDLE && !st_ff.start)
    else $error("start with empty mask began a scan");

  a_result_hold: assert property (
    !(st_ff.fsm == ASQ_CONVERT && st_ff.cnt == 8'h00)
    |=> $stable(st_ff.res))
    else $error("result register changed outside capture");

  a_flag_write: assert property (
    (wr_ctl &&
     !(st_ff.fsm == ASQ_CONVERT && st_ff.cnt == 8'h00 && last_chan))
    |=> st_ff.flag == $past(wbyte[`ASQ_CTL_FLAG_BIT]))
    else $error("completion flag write not stored");

  a_samp_load: assert property (
    $rose(sample_en) |-> st_ff.cnt == $past(samp_clks) - 8'h01)
    else $error("sampling count not loaded from table");

  a_conv_load: assert property (
    (st_ff.fsm == ASQ_SAMPLE && st_ff.cnt == 8'h00 &&
     !(wr_ctl && !wbyte[`ASQ_CTL_START_BIT]))
    |=> conv_active &&
        st_ff.cnt == $past(conv_clks) - $past(samp_clks) - 8'h01)
    else $error("conversion count not loaded from table");

endmodule : asq_scan_sequencer

//--- asq_map.svh
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH

// register byte addresses on the 16-bit special function bus
`define ASQ_CTL_ADDR      11'h43e
`define ASQ_SEL_ADDR      11'h43f
`define ASQ_CFG_ADDR      11'h4b9
// eight result registers at 4b0..4b7: upper address bits of that block
`define ASQ_RES_BASE_HI   8'h96

// control register fields
`define ASQ_CTL_MODE_BIT  2
`define ASQ_CTL_START_BIT 1
`define ASQ_CTL_FLAG_BIT  0

// reset values of the stored registers
`define ASQ_CTL_RESET     3'h0
`define ASQ_SEL_RESET     8'h00
`define ASQ_CFG_RESET     4'h0
`define ASQ_RES_RESET     8'h00

// conversion time per timing setting, in oscillator clocks; entry f first
`define ASQ_CONV_TABLE {8'hb0, 8'hac, 8'h98, 8'h8a, 8'h94, 8'h86, 8'h82, \
  8'h7e, 8'h66, 8'h76, 8'h6a, 8'h66, 8'h62, 8'h52, 8'h4e, 8'h46}
// sampling time per timing setting, in oscillator clocks; entry f first
`define ASQ_SAMP_TABLE {8'h18, 8'h16, 8'h14, 8'h14, 8'h20, 8'h12, 8'h10, \
  8'h0e, 8'h0e, 8'h18, 8'h0c, 8'h0a, 8'h08, 8'h08, 8'h06, 8'h04}

`endif

//--- asq_pkg.sv
package asq_pkg;

  // scan sequencer states, one-hot
  typedef enum logic [2:0] {
    ASQ_IDLE    = 3'b001,
    ASQ_SAMPLE  = 3'b010,
    ASQ_CONVERT = 3'b100
  } asq_state_t;

  // whole state of the sequencer
  typedef struct packed {
    asq_state_t      fsm;
    logic            mode;
    logic            start;
    logic            flag;
    logic [7:0]      chsel;
    logic [3:0]      tcfg;
    logic [2:0]      chan;
    logic [7:0]      cnt;
    logic [7:0][7:0] res;
    logic [7:0]      rdata;
    logic            irq;
    logic            samp;
    logic            conv;
  } asq_regs_t;

endpackage : asq_pkg

//--- asq_core_model.sv
module asq_core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       conv_active,
  input  wire logic [2:0] conv_channel,
  output      logic [7:0] conv_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] tick_ff;

  // value moves every cycle so a capture one cycle off is caught
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 5'h00;
    end else begin
      tick_ff <= tick_ff + 5'h03;
    end
  end

  // no held value between conversions: the core shows the inverse
  assign conv_data = conv_active ? {conv_channel, tick_ff}
                                 : ~{conv_channel, tick_ff};
endmodule : asq_core_model

//--- asq_scan_sequencer_tb.sv
module asq_scan_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [10:0] sfr_addr = 11'h000;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [15:0] sfr_wdata = 16'h0000;
  logic [15:0] sfr_rdata;
  logic [7:0]  conv_data;
  logic        ce = 1'b0;
  logic        ge = 1'b0;
  logic [3:0]  cp = 4'h0;
  logic [3:0]  rp = 4'h0;
  logic [3:0]  pp = 4'h0;
  logic        sample_en;
  logic        conv_active;
  logic        adc_irq_req;
  logic [2:0]  conv_channel;
  logic [2:0]  chp;
  logic [7:0]  last;
  logic [7:0]  res_m [8] = '{default: 8'h00};
  logic [10:0] ra [5] = '{11'h43e, 11'h43f, 11'h4b9, 11'h4b0, 11'h4ba};
  int          miscompares = 0;
  int          cmp_count = 0;
  int          seed = 32'h74df;
  int          cyc = 0;
  int          scnt = 0;
  int          ccnt = 0;
  int          tcfg = 0;
  bit          skip = 1'b0;
  bit          prev_ca = 1'b0;
  int          q[$];
  int ct[16] = '{70, 78, 82, 98, 102, 106, 118, 102, 126, 130, 134, 148,
                 138, 152, 172, 176};
  int st[16] = '{4, 6, 8, 8, 10, 12, 24, 14, 14, 16, 18, 32, 20, 20, 22, 24};

  always #12.5 clock = ~clock;

  asq_scan_sequencer dut_u (.clock(clock), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_data(conv_data),
    .converter_irq_enable(ce), .global_irq_enable(ge),
    .converter_priority(cp), .running_priority(rp),
    .pending_priority(pp), .sample_en(sample_en),
    .conv_active(conv_active), .conv_channel(conv_channel),
    .adc_irq_req(adc_irq_req));

  asq_core_model core_u (.clock(clock), .rst_n(rst_n),
    .conv_active(conv_active), .conv_channel(conv_channel),
    .conv_data(conv_data));

  task automatic finish_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle strobes, launched and released on rising edges
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    @(posedge clock);
    d = sfr_rdata;
  endtask : rd

  // polls status; bounded well above the longest eight-channel scan
  task automatic wait_flag;
    logic [15:0] d;
    d = 16'h0000;
    for (int k = 0; k < 800 && d[0] !== 1'b1; k++) rd(11'h43e, d);
  endtask : wait_flag

  // reference of window lengths, channel order and captured bytes
  always @(posedge clock) begin
    cyc++;
    if (cyc > 60000) begin
      miscompares++;
      finish_test;
    end
    if (prev_ca && !conv_active && !skip) begin
      chk(16'(scnt), 16'(st[tcfg]));
      chk(16'(scnt + ccnt), 16'(ct[tcfg]));
      chk(16'(chp), 16'(q.pop_front()));
      res_m[chp] = last;
    end
    if ((prev_ca && !conv_active) || (!sample_en && !conv_active)) begin
      scnt = 0;
      ccnt = 0;
    end
    if (sample_en === 1'b1) scnt++;
    if (conv_active === 1'b1) begin
      ccnt++;
      last = conv_data;
      chp = conv_channel;
    end
    prev_ca = conv_active;
  end

  initial begin
    logic [15:0] d;
    logic [7:0]  m;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d);
      chk(d[7:0], 8'h00);
    end
    // an empty mask must not start anything
    wr(11'h43e, 16'h0002);
    rd(11'h43e, d);
    chk(d[2:0], 3'b000);
    // single scans over every timing setting, all channels first, then random masks
    for (int t = 0; t < 16; t++) begin
      m = (t == 0) ? 8'hff : 8'($random(seed));
      if (m == 8'h00) m = 8'h80;
      {ce, ge, cp, rp, pp} <= 14'($random(seed));
      tcfg = t;
      wr(11'h4b9, {8'ha5, 4'h0, 4'(t)});
      wr(11'h43f, {8'h00, m});
      for (int n = 0; n < 8; n++) if (m[n]) q.push_back(n);
      wr(11'h43e, 16'h0002);
      wr(11'h43e, 16'h0002);
      rd(11'h43e, d);
      chk(d[2:0], 3'b010);
      wait_flag;
      rd(11'h43e, d);
      chk(d[2:0], 3'b001);
      chk(adc_irq_req, ce & ge & (cp > rp) & (cp > pp));
      rd(11'h4b9, d);
      chk(d[7:0], {4'h0, 4'(t)});
      for (int n = 0; n < 8; n++) begin
        rd(11'h4b0 + 11'(n), d);
        chk(d[7:0], res_m[n]);
      end
      rd(11'h43e, d);
      chk(d[0], 1'b1);
      wr(11'h43e, 16'h0000);
      rd(11'h43e, d);
      chk({d[0], adc_irq_req}, 2'b00);
    end
    // continuous scan wraps from channel 7 back to channel 0
    tcfg = 0;
    wr(11'h4b9, 16'h0000);
    wr(11'h43f, 16'h0081);
    repeat (6) q.push_back(0);
    for (int i = 1; i < 12; i += 2) q.insert(i, 7);
    wr(11'h43e, 16'h0006);
    wait_flag;
    wr(11'h43e, 16'h0006);
    wait_flag;
    rd(11'h43e, d);
    chk(d[2:0], 3'b111);
    // abort mid-scan: everything stops on the next cycle
    skip = 1'b1;
    chk(sample_en | conv_active, 1'b1);
    wr(11'h43e, 16'h0000);
    // look after the abort edge has settled the outputs
    @(negedge clock);
    chk({sample_en, conv_active}, 2'b00);
    repeat (200) @(posedge clock);
    rd(11'h43e, d);
    chk({d[1], sample_en, conv_active}, 3'b000);
    finish_test;
  end
endmodule : asq_scan_sequencer_tb
